// [logic/telegram_pkg.sv]
`default_nettype none
package telegram_pkg;
   // Cyclic data layouts
   typedef enum logic {TEL_STANDARD, TEL_VENDOR} telegram_e;
   // Frame lengths in bytes, and the frame width in bits
   localparam logic [3:0] RX_FRAME_LEN = 4'h4;
   localparam logic [3:0] TX_LEN_STANDARD = 4'hC;
   localparam logic [3:0] TX_LEN_VENDOR = 4'h8;
   localparam int FRAME_BITS = 96;
   // Control word and preset bit positions
   localparam int PRESET_REQ_BIT = 12;
   localparam int ABS_REQ_BIT = 13;
   localparam int PRESET_IGNORED_BIT = 31;
   // Slot range for encoder objects
   localparam logic [15:0] SLOT_MIN = 16'h0001;
   localparam logic [15:0] SLOT_MAX = 16'h7FFF;
   // Optional function identifiers
   localparam logic [2:0] FUNC_SCALING = 3'h0;
   localparam logic [2:0] FUNC_PRESET = 3'h1;
   localparam logic [2:0] FUNC_ISOCHRONOUS = 3'h2;
   localparam logic [2:0] FUNC_BASE_ACCESS = 3'h3;
   localparam logic [2:0] FUNC_VELOCITY = 3'h4;
   // Alarm source codes
   localparam logic [1:0] ALARM_MEASURING = 2'h1;
   localparam logic [1:0] ALARM_STATE_MACHINE = 2'h2;
endpackage
`default_nettype wire

// [logic/frame_if.sv]
`default_nettype none
interface frame_if;
   logic load;
   logic [95:0] frame;
   logic [3:0] len;
   logic busy;
   modport src (output load, output frame, output len, input busy);
   modport snk (input load, input frame, input len, output busy);
endinterface
`default_nettype wire

// [logic/frame_serializer.sv]
`default_nettype none
module frame_serializer
   import telegram_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   frame_if.snk fr,
   input wire logic i_tx_ready,
   output logic o_tx_valid,
   output logic [7:0] o_tx_byte,
   output logic o_tx_last
);
   logic [FRAME_BITS-1:0] frame_q, frame_d;
   logic [3:0] cnt_q, cnt_d;
   logic valid_q, valid_d, last_q, last_d;

   // Shift out the top byte first, so every field leaves most significant byte first
   always_comb begin
      frame_d = frame_q;
      cnt_d = cnt_q;
      if (cnt_q == 4'h0) begin
         if (fr.load) begin
            frame_d = fr.frame;
            cnt_d = fr.len;
         end
      end else if (i_tx_ready) begin
         frame_d = {frame_q[FRAME_BITS-9:0], 8'h00};
         cnt_d = cnt_q - 4'h1;
      end
      // Flags come from the next count, so the ports are flop outputs with no decode behind
      valid_d = (cnt_d != 4'h0);
      last_d = (cnt_d == 4'h1);
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         frame_q <= '0;
         cnt_q <= 4'h0;
         valid_q <= 1'b0;
         last_q <= 1'b0;
      end else if (i_ce) begin
         frame_q <= frame_d;
         cnt_q <= cnt_d;
         valid_q <= valid_d;
         last_q <= last_d;
      end
   end

   // All outputs are plain flop taps
   assign fr.busy = valid_q;
   assign o_tx_valid = valid_q;
   assign o_tx_byte = frame_q[FRAME_BITS-1:FRAME_BITS-8];
   assign o_tx_last = last_q;
endmodule
`default_nettype wire

// [logic/encoder_cyclic_telegram_io.sv]
// Contract
// - After reset the standard layout is used until another layout is selected.
// - The standard set-point frame is 4 bytes: encoder control word two, then sensor control word.
// - The standard actual frame is 12 bytes: state word two, sensor state, primary, secondary.
// - The vendor set-point frame is a 4-byte preset whose bit 31 is ignored.
// - The vendor actual frame is 8 bytes: primary position then velocity.
// - Vendor position and velocity are sent as full 32-bit values.
// - The preset is applied when sensor control bit 12 goes high and then low again, in the higher class only.
// - Encoder objects never use slot 0 and only use slots 1 to 0x7FFF.
// - Each encoder object maps to one slot holding a module access submodule with its record.
// - The lower class offers base access, limited setup and no isochronous mode.
// - The higher class offers scaling, preset, isochronous mode and base access.
// - Every optional function query is answered with supported or not.
// - A rising measuring task or state machine exception raises an alarm; if both rise together only the measuring alarm is raised.
// - The cyclic link runs at 100 Mbit/s full duplex.
// - Without an error the secondary field is the position only when bit 13 is set, else zero.
`default_nettype none
module encoder_cyclic_telegram_io
   import telegram_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_tel_vendor,
   input wire logic i_class_high,
   input wire logic [15:0] i_slot_cfg,
   input wire logic i_rx_sof,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_byte,
   input wire logic i_tx_req,
   input wire logic i_tx_ready,
   input wire logic [15:0] i_enc_state_word_two,
   input wire logic [15:0] i_sensor_state_word,
   input wire logic [31:0] i_position,
   input wire logic [31:0] i_velocity,
   input wire logic i_error_active,
   input wire logic [31:0] i_error_code,
   input wire logic i_func_query,
   input wire logic [2:0] i_func_id,
   input wire logic i_exc_measuring,
   input wire logic i_exc_state_machine,
   output logic o_tel_vendor,
   output logic [15:0] o_encoder_ctrl_word_two,
   output logic [15:0] o_sensor_ctrl_word,
   output logic [31:0] o_preset_position_value,
   output logic o_preset_apply,
   output logic o_tx_valid,
   output logic [7:0] o_tx_byte,
   output logic o_tx_last,
   output logic o_func_ack,
   output logic o_func_supported,
   output logic o_isochronous_ok,
   output logic o_scaling_ok,
   output logic [15:0] o_slot_num,
   output logic o_map_record_present,
   output logic o_alarm_req,
   output logic [1:0] o_alarm_source,
   output logic o_link_100m_fd
);
   frame_if fr ();

   // Reset release through two flops; assertion stays asynchronous
   logic rst_meta_q, rst_sync_q;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Answer for an optional function under the current class
   function automatic logic func_ok(input logic [2:0] id, input logic high);
      if (id == FUNC_BASE_ACCESS) begin
         func_ok = 1'b1;
      end else if (id == FUNC_SCALING || id == FUNC_PRESET || id == FUNC_ISOCHRONOUS) begin
         func_ok = high;
      end else begin
         func_ok = 1'b0;
      end
   endfunction

   telegram_e tel_q, tel_d;
   logic [23:0] rx_sh_q, rx_sh_d;
   logic [1:0] rx_cnt_q, rx_cnt_d;
   logic rx_active_q, rx_active_d;
   logic [15:0] ectl_q, ectl_d;
   logic [15:0] sctl_q, sctl_d;
   logic [31:0] preset_q, preset_d;
   logic apply_q, apply_d;
   logic fack_q, fack_d, fsup_q, fsup_d;
   logic iso_q, iso_d, scal_q, scal_d;
   logic [15:0] slot_q, slot_d;
   logic exm_q, exm_d, exs_q, exs_d;
   logic alarm_q, alarm_d;
   logic [1:0] asrc_q, asrc_d;
   logic [31:0] rx_word;
   logic [31:0] secondary;

   assign rx_word = {rx_sh_q, i_rx_byte};

   // Secondary field carries the error code, the position on request, or zero
   always_comb begin
      if (i_error_active) begin
         secondary = i_error_code;
      end else if (sctl_q[ABS_REQ_BIT]) begin
         secondary = i_position;
      end else begin
         secondary = 32'h0000_0000;
      end
   end

   // Actual-value frame build, left aligned so the serializer sends the top byte first
   always_comb begin
      fr.load = i_tx_req && !fr.busy;
      if (tel_q == TEL_VENDOR) begin
         fr.frame = {i_position, i_velocity, 32'h0000_0000};
         fr.len = TX_LEN_VENDOR;
      end else begin
         fr.frame = {i_enc_state_word_two, i_sensor_state_word, i_position, secondary};
         fr.len = TX_LEN_STANDARD;
      end
   end

   // Next-state for receive, control, capability and alarm state
   always_comb begin
      tel_d = tel_q;
      rx_sh_d = rx_sh_q;
      rx_cnt_d = rx_cnt_q;
      rx_active_d = rx_active_q;
      ectl_d = ectl_q;
      sctl_d = sctl_q;
      preset_d = preset_q;
      apply_d = 1'b0;
      fack_d = i_func_query;
      fsup_d = fsup_q;
      iso_d = i_class_high;
      scal_d = i_class_high;
      slot_d = slot_q;
      exm_d = i_exc_measuring;
      exs_d = i_exc_state_machine;
      alarm_d = 1'b0;
      asrc_d = asrc_q;
      // Layout changes only between frames so a frame never mixes layouts
      if (!rx_active_q && !i_rx_sof && !fr.busy && !i_tx_req) begin
         tel_d = i_tel_vendor ? TEL_VENDOR : TEL_STANDARD;
      end
      // Set-point bytes arrive most significant first
      if (i_rx_valid) begin
         if (i_rx_sof) begin
            rx_sh_d = {16'h0000, i_rx_byte};
            rx_cnt_d = 2'h1;
            rx_active_d = 1'b1;
         end else if (rx_active_q) begin
            rx_sh_d = {rx_sh_q[15:0], i_rx_byte};
            rx_cnt_d = rx_cnt_q + 2'h1;
            if (rx_cnt_q == 2'h3) begin
               rx_active_d = 1'b0;
               rx_cnt_d = 2'h0;
               if (tel_q == TEL_STANDARD) begin
                  ectl_d = rx_word[31:16];
                  sctl_d = rx_word[15:0];
                  // Falling edge of the home request completes the high-low pair
                  if (sctl_q[PRESET_REQ_BIT] && !rx_word[PRESET_REQ_BIT] && i_class_high) begin
                     apply_d = 1'b1;
                  end
               end else begin
                  preset_d = rx_word;
                  preset_d[PRESET_IGNORED_BIT] = 1'b0;
               end
            end
         end
      end
      if (i_func_query) begin
         fsup_d = func_ok(i_func_id, i_class_high);
      end
      // Slot 0 belongs to the device itself; bad settings fall back to the first slot
      if (i_slot_cfg >= SLOT_MIN && i_slot_cfg <= SLOT_MAX) begin
         slot_d = i_slot_cfg;
      end else begin
         slot_d = SLOT_MIN;
      end
      // Rising edges raise one alarm; measuring faults take priority
      if (i_exc_measuring && !exm_q) begin
         alarm_d = 1'b1;
         asrc_d = ALARM_MEASURING;
      end else if (i_exc_state_machine && !exs_q) begin
         alarm_d = 1'b1;
         asrc_d = ALARM_STATE_MACHINE;
      end
   end

   always_ff @(posedge i_mclk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         tel_q <= TEL_STANDARD;
         rx_sh_q <= 24'h000000;
         rx_cnt_q <= 2'h0;
         rx_active_q <= 1'b0;
         ectl_q <= 16'h0000;
         sctl_q <= 16'h0000;
         preset_q <= 32'h0000_0000;
         apply_q <= 1'b0;
         fack_q <= 1'b0;
         fsup_q <= 1'b0;
         iso_q <= 1'b0;
         scal_q <= 1'b0;
         slot_q <= SLOT_MIN;
         exm_q <= 1'b0;
         exs_q <= 1'b0;
         alarm_q <= 1'b0;
         asrc_q <= 2'h0;
      end else if (i_ce) begin
         tel_q <= tel_d;
         rx_sh_q <= rx_sh_d;
         rx_cnt_q <= rx_cnt_d;
         rx_active_q <= rx_active_d;
         ectl_q <= ectl_d;
         sctl_q <= sctl_d;
         preset_q <= preset_d;
         apply_q <= apply_d;
         fack_q <= fack_d;
         fsup_q <= fsup_d;
         iso_q <= iso_d;
         scal_q <= scal_d;
         slot_q <= slot_d;
         exm_q <= exm_d;
         exs_q <= exs_d;
         alarm_q <= alarm_d;
         asrc_q <= asrc_d;
      end
   end

   frame_serializer u_ser (
      .i_clk(i_mclk),
      .i_rst_b(rst_sync_q),
      .i_ce(i_ce),
      .fr(fr),
      .i_tx_ready(i_tx_ready),
      .o_tx_valid(o_tx_valid),
      .o_tx_byte(o_tx_byte),
      .o_tx_last(o_tx_last)
   );

   // Register taps to the ports
   assign o_tel_vendor = (tel_q == TEL_VENDOR);
   assign o_encoder_ctrl_word_two = ectl_q;
   assign o_sensor_ctrl_word = sctl_q;
   assign o_preset_position_value = preset_q;
   assign o_preset_apply = apply_q;
   assign o_func_ack = fack_q;
   assign o_func_supported = fsup_q;
   assign o_isochronous_ok = iso_q;
   assign o_scaling_ok = scal_q;
   assign o_slot_num = slot_q;
   assign o_map_record_present = rst_sync_q;
   assign o_alarm_req = alarm_q;
   assign o_alarm_source = asrc_q;
   assign o_link_100m_fd = rst_sync_q;
endmodule
`default_nettype wire

// [bench/telegram_chk.sv]
`default_nettype none
module telegram_chk
   import telegram_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_class_high,
   input wire logic i_func_query,
   input wire logic [2:0] i_func_id,
   input wire logic i_exc_measuring,
   input wire logic i_exc_state_machine,
   input wire logic i_tx_req,
   input wire logic i_tx_ready,
   input wire logic [31:0] o_preset_position_value,
   input wire logic o_preset_apply,
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_byte,
   input wire logic o_tx_last,
   input wire logic o_func_ack,
   input wire logic o_func_supported,
   input wire logic o_isochronous_ok,
   input wire logic o_scaling_ok,
   input wire logic [15:0] o_slot_num,
   input wire logic o_map_record_present,
   input wire logic o_alarm_req,
   input wire logic [1:0] o_alarm_source,
   input wire logic o_link_100m_fd
);
   logic [1:0] up_q;
   logic [1:0] up_d;
   logic up;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   // Internal reset trails the pin by two edges, so judge outputs only after that
   always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) up_q <= 2'h0;
      else up_q <= up_d;
   end
   assign up = (up_q == 2'h3);
   // Steps of an actual-value transfer
   sequence tx_taken;
      up && i_tx_req && !o_tx_valid;
   endsequence
   sequence byte_stalled;
      o_tx_valid && !i_tx_ready;
   endsequence
   preset_msb_a: assert property (up |-> !o_preset_position_value[31])
      else $error("preset bit 31 not cleared");
   apply_pulse_a: assert property (o_preset_apply |=> !o_preset_apply)
      else $error("preset apply longer than one cycle");
   slot_range_a: assert property (o_slot_num >= SLOT_MIN && o_slot_num <= SLOT_MAX)
      else $error("slot number out of range");
   fixed_caps_a: assert property (up |-> o_map_record_present && o_link_100m_fd)
      else $error("record or link flag low");
   class_caps_a: assert property (up && $past(up) |-> o_scaling_ok == $past(i_class_high) &&
      o_isochronous_ok == $past(i_class_high))
      else $error("class capabilities wrong");
   func_answer_a: assert property (up && i_func_query |=> o_func_ack &&
      o_func_supported == ($past(i_func_id) == FUNC_BASE_ACCESS ||
      ($past(i_func_id) < FUNC_BASE_ACCESS && $past(i_class_high))))
      else $error("function answer wrong");
   alarm_meas_a: assert property (up && $rose(i_exc_measuring) |=> o_alarm_req &&
      o_alarm_source == ALARM_MEASURING)
      else $error("measuring alarm missing");
   alarm_state_a: assert property (up && $rose(i_exc_state_machine) && !$rose(i_exc_measuring)
      |=> o_alarm_req && o_alarm_source == ALARM_STATE_MACHINE)
      else $error("state machine alarm missing");
   tx_start_a: assert property (tx_taken |=> o_tx_valid)
      else $error("frame did not start");
   tx_hold_a: assert property (byte_stalled |=> o_tx_valid && $stable(o_tx_byte) &&
      $stable(o_tx_last))
      else $error("byte changed while stalled");
endmodule
bind encoder_cyclic_telegram_io telegram_chk chk (.i_mclk, .i_rst_b, .i_class_high, .i_func_query,
   .i_func_id, .i_exc_measuring, .i_exc_state_machine, .i_tx_req, .i_tx_ready,
   .o_preset_position_value, .o_preset_apply, .o_tx_valid, .o_tx_byte, .o_tx_last, .o_func_ack,
   .o_func_supported, .o_isochronous_ok, .o_scaling_ok, .o_slot_num, .o_map_record_present,
   .o_alarm_req, .o_alarm_source, .o_link_100m_fd);
`default_nettype wire

// [bench/io_ctrl_model.sv]
`default_nettype none
module io_ctrl_model (
   input wire logic i_clk,
   output logic o_sof,
   output logic o_valid,
   output logic [7:0] o_byte,
   output logic o_ready,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_byte,
   input wire logic i_tx_last
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_sof = 1'b0;
      o_valid = 1'b0;
      o_byte = 8'h00;
      o_ready = 1'b0;
   end
   // Four set-point bytes back to back, most significant first
   task automatic send(input logic [31:0] w);
      for (int i = 3; i >= 0; i--) begin
         @(negedge i_clk);
         o_sof = (i == 3);
         o_valid = 1'b1;
         o_byte = w[i*8 +: 8];
      end
      @(negedge i_clk);
      o_sof = 1'b0;
      o_valid = 1'b0;
      o_byte = ~o_byte; // Idle line must not show a stale byte
   endtask
   // Ready held negedge to negedge, so an accept is known one half cycle later
   task automatic recv(output logic [95:0] f, output int n, output bit ok);
      logic v;
      logic l;
      logic [7:0] b;
      f = '0;
      n = 0;
      ok = 1'b0;
      v = 1'b0;
      l = 1'b0;
      b = 8'h00;
      for (int c = 0; c < 200 && !ok; c++) begin
         @(negedge i_clk);
         if (v && o_ready) begin
            f = {f[87:0], b};
            n++;
            ok = l;
         end
         v = i_tx_valid;
         b = i_tx_byte;
         l = i_tx_last;
         o_ready = !ok && ($urandom_range(2, 0) != 0); // Random stalls
      end
   endtask
endmodule
`default_nettype wire

// [bench/encoder_cyclic_telegram_io_tb_top.sv]
`default_nettype none
module encoder_cyclic_telegram_io_tb_top
   import telegram_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst_b = 1'b0, vend = 1'b0, cls = 1'b0, req = 1'b0, err = 1'b0;
   logic fq = 1'b0, exm = 1'b0, exs = 1'b0, sof, valid, ready, tv, tl, apply, tel;
   logic ce = 1'b1;
   logic [2:0] fid = 3'h0;
   logic [7:0] rxb, tb;
   logic [15:0] slot = 16'h0000, esw = 16'h0000, ssw = 16'h0000, ecw, scw, snum;
   logic [31:0] pos = 32'h0, vel = 32'h0, ecode = 32'h0, preset, w;
   int err_total = 0, n_compared = 0, n_apply = 0;
   encoder_cyclic_telegram_io DUT (.i_mclk(clk), .i_rst_b(rst_b), .i_ce(ce),
      .i_tel_vendor(vend), .i_class_high(cls), .i_slot_cfg(slot), .i_rx_sof(sof),
      .i_rx_valid(valid), .i_rx_byte(rxb), .i_tx_req(req), .i_tx_ready(ready),
      .i_enc_state_word_two(esw), .i_sensor_state_word(ssw), .i_position(pos),
      .i_velocity(vel), .i_error_active(err), .i_error_code(ecode), .i_func_query(fq),
      .i_func_id(fid), .i_exc_measuring(exm), .i_exc_state_machine(exs), .o_tel_vendor(tel),
      .o_encoder_ctrl_word_two(ecw), .o_sensor_ctrl_word(scw), .o_preset_position_value(preset),
      .o_preset_apply(apply), .o_tx_valid(tv), .o_tx_byte(tb), .o_tx_last(tl), .o_func_ack(),
      .o_func_supported(), .o_isochronous_ok(), .o_scaling_ok(), .o_slot_num(snum),
      .o_map_record_present(), .o_alarm_req(), .o_alarm_source(), .o_link_100m_fd());
   io_ctrl_model m (.i_clk(clk), .o_sof(sof), .o_valid(valid), .o_byte(rxb), .o_ready(ready),
      .i_tx_valid(tv), .i_tx_byte(tb), .i_tx_last(tl));
   // 40 MHz clock
   initial forever #12.5 clk = ~clk;
   // Apply is one cycle wide, so one falling edge sees each pulse
   always @(negedge clk) if (apply) n_apply++;
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("Mismatches %0d, compared %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Secondary field follows error flag, then the absolute request bit
   function automatic logic [95:0] exp_std(input logic [15:0] c);
      exp_std = {esw, ssw, pos, err ? ecode : (c[ABS_REQ_BIT] ? pos : 32'h0)};
   endfunction
   task automatic fetch(input logic [95:0] e, input int len);
      logic [95:0] f;
      int n;
      bit ok;
      @(negedge clk);
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      m.recv(f, n, ok);
      if (!ok) begin
         err_total++; // Timeout counts as a mismatch
         complete_run;
      end else begin
         chk(96'(n), 96'(len));
         chk(f, e);
      end
   endtask
   initial begin
      void'($urandom(72609));
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      chk(96'(tel), 96'(TEL_STANDARD));
      for (int k = 0; k < 5; k++) begin
         slot = (k == 0) ? 16'h0000 : (k == 4) ? 16'($urandom) : 16'h7FFE + 16'(k);
         repeat (3) @(negedge clk);
         chk(96'(snum), 96'((slot == 16'h0 || slot > SLOT_MAX) ? SLOT_MIN : slot));
      end
      // Clock enable low must freeze the slot register
      slot = 16'h0003;
      repeat (3) @(negedge clk);
      ce = 1'b0;
      slot = 16'h0004;
      repeat (3) @(negedge clk);
      chk(96'(snum), 96'(16'h0003));
      ce = 1'b1;
      repeat (3) @(negedge clk);
      chk(96'(snum), 96'(16'h0004));
      for (int k = 0; k < 16; k++) begin
         fid = k[2:0];
         cls = k[3];
         fq = 1'b1;
         @(negedge clk);
         fq = 1'b0;
         @(negedge clk);
      end
      {exm, exs} = 2'b10;
      repeat (3) @(negedge clk);
      {exm, exs} = 2'b01;
      repeat (3) @(negedge clk);
      {exm, exs} = 2'b00;
      repeat (2) @(negedge clk);
      {exm, exs} = 2'b11;
      repeat (3) @(negedge clk);
      for (int k = 0; k < 6; k++) begin
         w = $urandom;
         w[ABS_REQ_BIT] = k[0];
         err = (k == 5);
         {esw, ssw} = $urandom;
         pos = $urandom;
         ecode = $urandom;
         m.send(w);
         chk(96'({ecw, scw}), 96'(w));
         fetch(exp_std(w[15:0]), 12);
      end
      cls = 1'b1;
      vend = 1'b1;
      repeat (3) @(negedge clk);
      chk(96'(tel), 96'(TEL_VENDOR));
      w = $urandom | 32'h80000000;
      m.send(w);
      chk(96'(preset), 96'(w & 32'h7FFFFFFF));
      pos = $urandom | 32'h80000000;
      vel = $urandom | 32'h80000001;
      fetch(96'({pos, vel}), 8);
      vend = 1'b0;
      repeat (3) @(negedge clk);
      n_apply = 0;
      m.send(32'h00001000);
      m.send(32'h00000000);
      repeat (2) @(negedge clk);
      chk(96'(n_apply), 96'(1));
      cls = 1'b0;
      m.send(32'h00001000);
      m.send(32'h00000000);
      repeat (2) @(negedge clk);
      chk(96'(n_apply), 96'(1));
      complete_run;
   end
endmodule
`default_nettype wire
